// ==== ops_map.vh ====
// Register offsets, field positions, codes and reset values of the slave-mode timer
`ifndef OPS_MAP_VH
`define OPS_MAP_VH

// Register byte offsets
`define OPS_OFF_CTRL    8'h00
`define OPS_OFF_SLAVE   8'h08
`define OPS_OFF_IEN     8'h0C
`define OPS_OFF_STAT    8'h10
`define OPS_OFF_EVGEN   8'h14
`define OPS_OFF_CHMODE  8'h18
`define OPS_OFF_POL     8'h20
`define OPS_OFF_COUNT   8'h24
`define OPS_OFF_PRESC   8'h28
`define OPS_OFF_RELOAD  8'h2C
`define OPS_OFF_CMP     8'h34

// Control register bits
`define OPS_CTRL_RUN     0
`define OPS_CTRL_UDIS    1
`define OPS_CTRL_UPD_SRC 2
`define OPS_CTRL_SINGLE  3
`define OPS_CTRL_RLD_PE  7
// Slave register fields
`define OPS_SLV_MODE    0
`define OPS_SLV_TSEL    4
// Enable, status and event-generation bits
`define OPS_IEN_TRIG    6
`define OPS_STAT_UIF    0
`define OPS_STAT_TRIG   6
`define OPS_EVG_FUPD    0
`define OPS_EVG_TG      6
// Channel mode fields
`define OPS_CHM_SRC1    0
`define OPS_CHM_FE      2
`define OPS_CHM_PE      3
`define OPS_CHM_OCM     4
`define OPS_CHM_SRC2    8
// Polarity bits
`define OPS_POL_P1      1
`define OPS_POL_NP1     3
`define OPS_POL_P2      5
`define OPS_POL_NP2     7

// Slave mode codes
`define OPS_MODE_OFF    3'h0
`define OPS_MODE_RESET  3'h4
`define OPS_MODE_GATED  3'h5
`define OPS_MODE_TRIG   3'h6
`define OPS_MODE_EXTCLK 3'h7
// Trigger select codes
`define OPS_TSEL_IN1EDG 3'h4
`define OPS_TSEL_IN1    3'h5
`define OPS_TSEL_IN2    3'h6
// Output mode codes
`define OPS_OCM_FROZEN  3'h0
`define OPS_OCM_ACTIVE  3'h1
`define OPS_OCM_INACT   3'h2
`define OPS_OCM_TOGGLE  3'h3
`define OPS_OCM_FLOW    3'h4
`define OPS_OCM_FHIGH   3'h5
`define OPS_OCM_PWM1    3'h6
`define OPS_OCM_PWM2    3'h7
// Channel source code routing the own input pin
`define OPS_CCS_PIN     2'h1

// Reset values
`define OPS_RST_ZERO    16'h0000
`define OPS_RST_RELOAD  16'hFFFF

`endif

// ==== ops_timer.v ====
// Single-pulse and slave-mode 16-bit upcounting timer with APB register access
`timescale 1ns/1ps
`include "ops_map.vh"

// Functional notes
// - Single-pulse mode stops counter at rollover
// - Update event in single-pulse clears run enable
// - Pulse starts at compare, lasts reload minus compare
// - Mode 111: high at match, low at reload
// - Single-pulse off: keep counting through updates
// - Trigger edge sets run enable, starting counter
// - Fast enable forces match level on trigger
// - Fast enable honoured only in PWM modes
// - Reset mode clears counter and prescaler on trigger
// - Reset trigger updates shadows when request source low
// - Reset trigger zeroes counter, sets flag, requests interrupt
// - Gated mode counts while trigger active and enabled
// - Gated mode flags both start and stop
// - Trigger mode starts counter on rising edge only
// - Trigger start begins counting and sets flag together
// - Slave actions lag input edge by resync stage
// - Source code 01 routes pin to filtered input
// - Debug halt freezes counter when freeze selected
// - Byte, halfword and word reads are accepted
module ops_timer #(
   parameter CW = 16
) (
   // Clock, reset and clock enable
   input  wire          pclk,
   input  wire          presetn,
   input  wire          ce,
   // APB slave
   input  wire          psel,
   input  wire          penable,
   input  wire          pwrite,
   input  wire [7:0]    paddr,
   input  wire [31:0]   pwdata,
   input  wire [3:0]    pstrb,
   output reg  [31:0]   prdata,
   output wire          pready,
   output wire          pslverr,
   // Timer inputs and internal triggers
   input  wire          ti1,
   input  wire          ti2,
   input  wire [3:0]    itr,
   // Debug
   input  wire          dbg_halt,
   input  wire          debug_freeze_select,
   // Channel and status outputs
   output reg           channel_reference_output,
   output reg           ch1_out,
   output wire          counter_run_enable,
   output wire          trig_irq
);

   // Address decode shared by read and write paths
   function sel;
      input [7:0] a;
      input [7:0] off;
      begin
         sel = (a[7:2] == off[7:2]);
      end
   endfunction

   // Register storage
   reg  [15:0]   ctrl_q;
   reg  [15:0]   slave_q;
   reg  [15:0]   ien_q;
   reg  [15:0]   stat_q;
   reg  [15:0]   chmode_q;
   reg  [15:0]   pol_q;
   reg  [CW-1:0] cnt_q;
   reg  [15:0]   psc_pre_q;
   reg  [15:0]   psc_sh_q;
   reg  [15:0]   psc_cnt_q;
   reg  [CW-1:0] rld_pre_q;
   reg  [CW-1:0] rld_sh_q;
   reg  [CW-1:0] cmp_pre_q;
   reg  [CW-1:0] cmp_sh_q;
   reg           perr_q;
   reg           force_q;
   reg           hit_q;
   reg           trig_in_q;
   // Input synchronisers
   reg           ti1_s1_q;
   reg           ti1_s2_q;
   reg           ti1_s3_q;
   reg           ti2_s1_q;
   reg           ti2_s2_q;
   reg  [3:0]    itr_q;

   // Field aliases
   wire          run      = ctrl_q[`OPS_CTRL_RUN];
   wire          udis     = ctrl_q[`OPS_CTRL_UDIS];
   wire          upd_src  = ctrl_q[`OPS_CTRL_UPD_SRC];
   wire          single   = ctrl_q[`OPS_CTRL_SINGLE];
   wire          rld_pe   = ctrl_q[`OPS_CTRL_RLD_PE];
   wire [2:0]    smode    = slave_q[`OPS_SLV_MODE +: 3];
   wire [2:0]    tsel     = slave_q[`OPS_SLV_TSEL +: 3];
   wire [1:0]    src1     = chmode_q[`OPS_CHM_SRC1 +: 2];
   wire [1:0]    src2     = chmode_q[`OPS_CHM_SRC2 +: 2];
   wire          fast_en  = chmode_q[`OPS_CHM_FE];
   wire          cmp_pe   = chmode_q[`OPS_CHM_PE];
   wire [2:0]    ocm      = chmode_q[`OPS_CHM_OCM +: 3];

   // APB access phase decode
   wire          acc      = psel & penable;
   wire          hw_ok    = (pstrb[1:0] == 2'b11);
   wire          wr       = acc & pwrite & hw_ok & ce & ~perr_q;
   wire          wr_ctrl  = wr & sel(paddr, `OPS_OFF_CTRL);
   wire          wr_slave = wr & sel(paddr, `OPS_OFF_SLAVE);
   wire          wr_ien   = wr & sel(paddr, `OPS_OFF_IEN);
   wire          wr_stat  = wr & sel(paddr, `OPS_OFF_STAT);
   wire          wr_evg   = wr & sel(paddr, `OPS_OFF_EVGEN);
   wire          wr_chm   = wr & sel(paddr, `OPS_OFF_CHMODE);
   wire          wr_pol   = wr & sel(paddr, `OPS_OFF_POL);
   wire          wr_cnt   = wr & sel(paddr, `OPS_OFF_COUNT);
   wire          wr_psc   = wr & sel(paddr, `OPS_OFF_PRESC);
   wire          wr_rld   = wr & sel(paddr, `OPS_OFF_RELOAD);
   wire          wr_cmp   = wr & sel(paddr, `OPS_OFF_CMP);
   wire          mapped   = sel(paddr, `OPS_OFF_CTRL)   | sel(paddr, `OPS_OFF_SLAVE)  |
                            sel(paddr, `OPS_OFF_IEN)    | sel(paddr, `OPS_OFF_STAT)   |
                            sel(paddr, `OPS_OFF_EVGEN)  | sel(paddr, `OPS_OFF_CHMODE) |
                            sel(paddr, `OPS_OFF_POL)    | sel(paddr, `OPS_OFF_COUNT)  |
                            sel(paddr, `OPS_OFF_PRESC)  | sel(paddr, `OPS_OFF_RELOAD) |
                            sel(paddr, `OPS_OFF_CMP);
   // Software generated update and trigger events
   wire          fupd     = wr_evg & pwdata[`OPS_EVG_FUPD];
   wire          tg       = wr_evg & pwdata[`OPS_EVG_TG];

   // One access cycle; stalls while the clock enable is low
   assign pready  = ce;
   assign pslverr = acc & perr_q;
   assign counter_run_enable = run;
   assign trig_irq = stat_q[`OPS_STAT_TRIG] & ien_q[`OPS_IEN_TRIG];

   // Filtered inputs: pin reaches channel only with source code 01
   wire          fi1      = (src1 == `OPS_CCS_PIN) & (ti1_s2_q ^ pol_q[`OPS_POL_P1]);
   wire          fi2      = (src2 == `OPS_CCS_PIN) & (ti2_s2_q ^ pol_q[`OPS_POL_P2]);
   wire          ti1_ed   = (src1 == `OPS_CCS_PIN) & (ti1_s2_q ^ ti1_s3_q);

   // Trigger input selection
   reg           trig_in;
   always @* begin
      case (tsel)
         3'h0:             trig_in = itr_q[0];
         3'h1:             trig_in = itr_q[1];
         3'h2:             trig_in = itr_q[2];
         3'h3:             trig_in = itr_q[3];
         `OPS_TSEL_IN1EDG: trig_in = ti1_ed;
         `OPS_TSEL_IN1:    trig_in = fi1;
         `OPS_TSEL_IN2:    trig_in = fi2;
         default:          trig_in = 1'b0;
      endcase
   end

   // Edges of the resynchronised trigger
   wire          t_rise   = trig_in & ~trig_in_q;
   wire          t_fall   = ~trig_in & trig_in_q;
   wire          m_reset  = (smode == `OPS_MODE_RESET) & t_rise;
   wire          m_gated  = (smode == `OPS_MODE_GATED);
   wire          m_start  = (smode == `OPS_MODE_TRIG) & t_rise;
   wire          m_extclk = (smode == `OPS_MODE_EXTCLK);

   // Count enable, debug freeze and prescaler tick
   wire          freeze   = dbg_halt & debug_freeze_select;
   wire          gate_ok  = ~m_gated | trig_in;
   wire          cnt_on   = run & gate_ok & ~freeze;
   wire          psc_tick = cnt_on & (~m_extclk | t_rise);
   wire          psc_wrap = psc_tick & (psc_cnt_q == psc_sh_q);
   wire          ovf      = psc_wrap & (cnt_q == rld_sh_q);
   wire          reinit   = fupd | m_reset;
   // Update event from rollover, software, or reset trigger when source low
   wire          upd_evt  = ~udis & (ovf | fupd | (m_reset & ~upd_src));
   wire          uif_set  = ~udis & (ovf | (~upd_src & reinit));
   // Trigger flag sources
   wire          tif_set  = m_reset | m_start | tg |
                            (m_gated & run & (t_rise | t_fall));
   // Fast enable acts only in the PWM modes
   wire          pwm      = (ocm == `OPS_OCM_PWM1) | (ocm == `OPS_OCM_PWM2);
   wire          fast_go  = fast_en & pwm & m_start;

   // Input synchronisers and trigger history
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ti1_s1_q <= 1'b0;
         ti1_s2_q <= 1'b0;
         ti1_s3_q <= 1'b0;
         ti2_s1_q <= 1'b0;
         ti2_s2_q <= 1'b0;
         itr_q    <= 4'h0;
         trig_in_q <= 1'b0;
      end else if (ce) begin
         ti1_s1_q <= ti1;
         ti1_s2_q <= ti1_s1_q;
         ti1_s3_q <= ti1_s2_q;
         ti2_s1_q <= ti2;
         ti2_s2_q <= ti2_s1_q;
         itr_q    <= itr;
         trig_in_q <= trig_in;
      end
   end

   // Configuration registers
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slave_q  <= `OPS_RST_ZERO;
         ien_q    <= `OPS_RST_ZERO;
         chmode_q <= `OPS_RST_ZERO;
         pol_q    <= `OPS_RST_ZERO;
      end else if (ce) begin
         if (wr_slave)
            slave_q <= pwdata[15:0] & 16'h0077;
         if (wr_ien)
            ien_q <= pwdata[15:0] & 16'h0040;
         if (wr_chm)
            chmode_q <= pwdata[15:0] & 16'h037F;
         if (wr_pol)
            pol_q <= pwdata[15:0] & 16'h00AA;
      end
   end

   // Control register with hardware set and clear of run enable
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= `OPS_RST_ZERO;
      end else if (ce) begin
         if (wr_ctrl)
            ctrl_q <= pwdata[15:0] & 16'h008F;
         if (upd_evt & single)
            ctrl_q[`OPS_CTRL_RUN] <= 1'b0;
         if (m_start)
            ctrl_q[`OPS_CTRL_RUN] <= 1'b1;
      end
   end

   // Status flags: write zero clears, a hardware set in the same cycle wins
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_q <= `OPS_RST_ZERO;
      end else if (ce) begin
         if (wr_stat)
            stat_q <= stat_q & pwdata[15:0];
         if (uif_set)
            stat_q[`OPS_STAT_UIF] <= 1'b1;
         if (tif_set)
            stat_q[`OPS_STAT_TRIG] <= 1'b1;
      end
   end

   // Preload and shadow registers, shadows load on update event
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         psc_pre_q <= `OPS_RST_ZERO;
         psc_sh_q  <= `OPS_RST_ZERO;
         rld_pre_q <= {CW{1'b1}};
         rld_sh_q  <= {CW{1'b1}};
         cmp_pre_q <= {CW{1'b0}};
         cmp_sh_q  <= {CW{1'b0}};
      end else if (ce) begin
         if (wr_psc)
            psc_pre_q <= pwdata[15:0];
         if (wr_rld)
            rld_pre_q <= pwdata[CW-1:0];
         if (wr_cmp)
            cmp_pre_q <= pwdata[CW-1:0];
         if (upd_evt) begin
            psc_sh_q <= wr_psc ? pwdata[15:0] : psc_pre_q;
            rld_sh_q <= wr_rld ? pwdata[CW-1:0] : rld_pre_q;
            cmp_sh_q <= wr_cmp ? pwdata[CW-1:0] : cmp_pre_q;
         end else begin
            if (wr_rld & ~rld_pe)
               rld_sh_q <= pwdata[CW-1:0];
            if (wr_cmp & ~cmp_pe)
               cmp_sh_q <= pwdata[CW-1:0];
         end
      end
   end

   // Counter and prescaler
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q     <= {CW{1'b0}};
         psc_cnt_q <= `OPS_RST_ZERO;
      end else if (ce) begin
         if (reinit) begin
            cnt_q     <= {CW{1'b0}};
            psc_cnt_q <= `OPS_RST_ZERO;
         end else begin
            if (psc_wrap)
               psc_cnt_q <= `OPS_RST_ZERO;
            else if (psc_tick)
               psc_cnt_q <= psc_cnt_q + 16'h0001;
            if (wr_cnt)
               cnt_q <= pwdata[CW-1:0];
            else if (ovf)
               cnt_q <= {CW{1'b0}};
            else if (psc_wrap)
               cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
         end
      end
   end

   // Compare match and fast-enable hold
   wire          hit      = (cnt_q == cmp_sh_q);
   wire          hit_evt  = hit & ~hit_q;
   wire          above    = (cnt_q >= cmp_sh_q);
   // Pulse ends as the count reaches the reload value
   wire          at_rld   = (cnt_q == rld_sh_q);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hit_q   <= 1'b0;
         force_q <= 1'b0;
      end else if (ce) begin
         hit_q <= hit;
         if (fast_go)
            force_q <= 1'b1;
         else if (upd_evt | ~pwm)
            force_q <= 1'b0;
      end
   end

   // Reference output per output mode
   reg           ref_d;
   always @* begin
      ref_d = channel_reference_output;
      case (ocm)
         `OPS_OCM_FROZEN: ref_d = channel_reference_output;
         `OPS_OCM_ACTIVE: if (hit_evt) ref_d = 1'b1;
         `OPS_OCM_INACT:  if (hit_evt) ref_d = 1'b0;
         `OPS_OCM_TOGGLE: if (hit_evt) ref_d = ~channel_reference_output;
         `OPS_OCM_FLOW:   ref_d = 1'b0;
         `OPS_OCM_FHIGH:  ref_d = 1'b1;
         `OPS_OCM_PWM1:   ref_d = ~above & ~force_q;
         `OPS_OCM_PWM2:   ref_d = (above & ~at_rld) | force_q;
         default:         ref_d = channel_reference_output;
      endcase
   end

   // Registered reference and polarity-applied channel output
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         channel_reference_output <= 1'b0;
         ch1_out                  <= 1'b0;
      end else if (ce) begin
         channel_reference_output <= ref_d;
         ch1_out                  <= ref_d ^ pol_q[`OPS_POL_P1];
      end
   end

   // Read mux, narrow registers zero-extended
   reg  [15:0]   rdata;
   always @* begin
      rdata = 16'h0000;
      if (sel(paddr, `OPS_OFF_CTRL))   rdata = ctrl_q;
      if (sel(paddr, `OPS_OFF_SLAVE))  rdata = slave_q;
      if (sel(paddr, `OPS_OFF_IEN))    rdata = ien_q;
      if (sel(paddr, `OPS_OFF_STAT))   rdata = stat_q;
      if (sel(paddr, `OPS_OFF_CHMODE)) rdata = chmode_q;
      if (sel(paddr, `OPS_OFF_POL))    rdata = pol_q;
      if (sel(paddr, `OPS_OFF_COUNT))  rdata = cnt_q;
      if (sel(paddr, `OPS_OFF_PRESC))  rdata = psc_pre_q;
      if (sel(paddr, `OPS_OFF_RELOAD)) rdata = rld_pre_q;
      if (sel(paddr, `OPS_OFF_CMP))    rdata = cmp_pre_q;
   end

   // Setup phase captures read data and the error decision
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         perr_q <= 1'b0;
      end else if (ce && psel && !penable) begin
         prdata <= {16'h0000, rdata};
         perr_q <= ~mapped | (pwrite & ~hw_ok);
      end
   end

endmodule // ops_timer

// ==== ops_timer_props.sv ====
// Concurrent checks on the ports of the single-pulse slave-mode timer
`timescale 1ns/1ps
`include "ops_map.vh"
module ops_timer_props (
   // Clock and reset
   input wire        pclk,
   input wire        presetn,
   input wire        ce,
   // Register bus
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [7:0]  paddr,
   input wire [31:0] pwdata,
   input wire [3:0]  pstrb,
   input wire        pready,
   input wire        pslverr,
   // Trigger pin and status
   input wire        ti2,
   input wire        counter_run_enable,
   input wire        trig_irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Accepted writes and the word they address
   wire       wr_ok   = psel && penable && pwrite && ce && (pstrb[1:0] == 2'b11);
   wire [7:0] word_a  = paddr & 8'hFC;
   wire       ctrl_wr = wr_ok && (word_a == `OPS_OFF_CTRL);
   reg  [6:0] slv_q;
   reg        single_q;
   reg        ien_q;
   reg  [1:0] src2_q;
   reg        p2_q;

   // Shadow copies of the fields that qualify the properties
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slv_q  <= 7'h00;
         single_q <= 1'b0;
         ien_q    <= 1'b0;
         src2_q   <= 2'h0;
         p2_q   <= 1'b0;
      end else if (wr_ok) begin
         case (word_a)
            `OPS_OFF_CTRL:   single_q <= pwdata[`OPS_CTRL_SINGLE];
            `OPS_OFF_SLAVE:  slv_q <= pwdata[6:0];
            `OPS_OFF_IEN:    ien_q <= pwdata[`OPS_IEN_TRIG];
            `OPS_OFF_CHMODE: src2_q <= pwdata[`OPS_CHM_SRC2 +: 2];
            `OPS_OFF_POL:    p2_q <= pwdata[`OPS_POL_P2];
            default: ;
         endcase
      end
   end

   // Second input routed, rising polarity, trigger-start mode
   wire trig_cfg = (slv_q[2:0] == `OPS_MODE_TRIG) && (slv_q[6:4] == `OPS_TSEL_IN2)
                   && (src2_q == `OPS_CCS_PIN) && !p2_q && ce;

   // Run stays low through the resync stage, then rises
   sequence s_held_off;
      !counter_run_enable [*2];
   endsequence
   sequence s_start_seen;
      ##1 s_held_off ##1 counter_run_enable;
   endsequence

   chk_trig_start: assert property ($rose(ti2) && trig_cfg && !counter_run_enable |-> s_start_seen)
      else $error("trigger start timing wrong");
   chk_trig_flag: assert property ($rose(ti2) && trig_cfg && ien_q && !counter_run_enable |-> ##3 trig_irq)
      else $error("trigger flag not raised with start");
   chk_gated_nostart: assert property ((slv_q[2:0] == `OPS_MODE_GATED) && !counter_run_enable && !ctrl_wr |=> !counter_run_enable)
      else $error("gated mode set run by itself");
   chk_repeat_run: assert property (!single_q && counter_run_enable && !ctrl_wr |=> counter_run_enable)
      else $error("run cleared in repetitive mode");
   chk_irq_masked: assert property (!ien_q |-> !trig_irq)
      else $error("trigger request while disabled");
   chk_byte_write: assert property (psel && penable && pwrite && (pstrb[1:0] != 2'b11) |-> pslverr)
      else $error("narrow write not refused");
   chk_read_ok: assert property (psel && penable && !pwrite && (word_a == `OPS_OFF_COUNT) |-> !pslverr)
      else $error("read refused");
   chk_unmapped_err: assert property (psel && penable && (word_a == 8'h04) |-> pslverr)
      else $error("unmapped access not refused");
   chk_ready_ce: assert property (psel && penable |-> pready == ce)
      else $error("ready does not follow clock enable");
endmodule // ops_timer_props

bind ops_timer ops_timer_props u_props (
   .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
   .pslverr(pslverr), .ti2(ti2), .counter_run_enable(counter_run_enable),
   .trig_irq(trig_irq)
);

// ==== tb_top.sv ====
// Self-checking bench for the single-pulse slave-mode timer
`timescale 1ns/1ps
`include "ops_map.vh"
module tb_top;
   // Design inputs
   reg         pclk, presetn, ce, psel, penable, pwrite;
   reg  [7:0]  paddr;
   reg  [31:0] pwdata;
   reg  [3:0]  pstrb;
   reg         ti1, ti2, dbg_halt, debug_freeze_select;
   // Design outputs
   wire [31:0] prdata;
   wire        pready, pslverr, ref_o, ch1_out, counter_run_enable, trig_irq;
   // Bench state
   integer     fails, checks_done, f_run, f_ref, f_irq, n_run, n_ref, n_ch, i;
   reg  [31:0] rdata, c0;
   reg         rerr;

   ops_timer dut (
      .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ti1(ti1), .ti2(ti2), .itr(4'h0),
      .dbg_halt(dbg_halt), .debug_freeze_select(debug_freeze_select),
      .channel_reference_output(ref_o), .ch1_out(ch1_out),
      .counter_run_enable(counter_run_enable), .trig_irq(trig_irq)
   );

   // Clock of 10 ns period
   always #5 pclk = ~pclk;

   task automatic stop_test;
      if (fails == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done = checks_done + 1;
      if (g !== e) begin
         fails = fails + 1;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One bus transfer: setup, then access held until ready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      pstrb  <= s;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rdata = prdata;
      rerr  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 4'hF);
   endtask

   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, 4'h0);
      chk(nm, e, rdata);
   endtask

   // Raise the second input and log when run, reference and request appear
   task automatic fire;
      f_run = 0; f_ref = 0; f_irq = 0; n_run = 0; n_ref = 0;
      n_ch = 0;
      ti2 <= 1'b1;
      for (i = 1; i <= 30; i = i + 1) begin
         @(posedge pclk);
         #1;
         if (counter_run_enable === 1'b1) n_run = n_run + 1;
         if (counter_run_enable === 1'b1 && f_run == 0) f_run = i;
         if (ref_o === 1'b1) n_ref = n_ref + 1;
         if (ref_o === 1'b1 && f_ref == 0) f_ref = i;
         if (trig_irq === 1'b1 && f_irq == 0) f_irq = i;
         if (ch1_out === 1'b1) n_ch = n_ch + 1;
      end
      ti2 <= 1'b0;
   endtask

   // Watchdog against a hung handshake
   initial begin
      #100000;
      fails = fails + 1;
      stop_test;
   end

   initial begin
      fails = 0; checks_done = 0; pclk = 1'b0; presetn = 1'b0; ce = 1'b1;
      psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
      pstrb = 4'h0; ti1 = 1'b0; ti2 = 1'b0; dbg_halt = 1'b0; debug_freeze_select = 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1; // Clock runs before any trigger arrives
      // Reset values and refused or narrow accesses
      rd("reload reset", `OPS_OFF_RELOAD, 32'h0000FFFF);
      apb(1'b1, `OPS_OFF_RELOAD, 32'h00001234, 4'h1);
      chk("byte write refused", 32'h0001FFFF, {rerr, rdata[15:0]});
      rd("reload kept", `OPS_OFF_RELOAD, 32'h0000FFFF);
      apb(1'b0, 8'h04, 32'h0, 4'h0);
      chk("unmapped error", 32'h1, rerr);
      apb(1'b0, `OPS_OFF_RELOAD + 8'h02, 32'h0, 4'h0);
      chk("byte read", 32'h0000FFFF, {rerr, rdata[15:0]});
      // Single pulse started by the second input
      wr(`OPS_OFF_SLAVE, 32'h00000066);
      wr(`OPS_OFF_CHMODE, 32'h00000170);
      wr(`OPS_OFF_IEN, 32'h00000040);
      wr(`OPS_OFF_CMP, 32'h00000002);
      wr(`OPS_OFF_RELOAD, 32'h00000005);
      wr(`OPS_OFF_CTRL, 32'h00000088);
      wr(`OPS_OFF_EVGEN, 32'h00000001);
      wr(`OPS_OFF_STAT, 32'h00000000);
      fire;
      chk("run start cycle", 32'h3, f_run);
      chk("flag start cycle", 32'h3, f_irq);
      chk("run length", 32'h6, n_run);
      chk("pulse length", 32'h3, n_ref);
      chk("output pulse length", 32'h3, n_ch);
      rd("count after pulse", `OPS_OFF_COUNT, 32'h0);
      // Fast enable in a PWM mode and in a non-PWM mode
      wr(`OPS_OFF_CMP, 32'h00000004);
      wr(`OPS_OFF_CHMODE, 32'h00000174);
      fire;
      chk("fast reference", 32'h1, (f_ref > 0 && f_ref <= 4));
      wr(`OPS_OFF_CHMODE, 32'h00000114);
      fire;
      chk("fast ignored", 32'h1, (f_ref > 4));
      // Repetitive counting and debug halt
      wr(`OPS_OFF_SLAVE, 32'h00000000);
      wr(`OPS_OFF_CTRL, 32'h00000081);
      repeat (20) @(posedge pclk);
      chk("run kept", 32'h1, counter_run_enable);
      dbg_halt <= 1'b1;
      debug_freeze_select <= 1'b1;
      apb(1'b0, `OPS_OFF_COUNT, 32'h0, 4'h0);
      c0 = rdata;
      rd("frozen count", `OPS_OFF_COUNT, c0);
      debug_freeze_select <= 1'b0;
      apb(1'b0, `OPS_OFF_COUNT, 32'h0, 4'h0);
      c0 = rdata;
      apb(1'b0, `OPS_OFF_COUNT, 32'h0, 4'h0);
      chk("count runs in halt", 32'h1, (c0 !== rdata));
      dbg_halt <= 1'b0;
      // Reset mode on the first input with a pending reload
      wr(`OPS_OFF_CHMODE, 32'h00000001);
      wr(`OPS_OFF_RELOAD, 32'h00000040);
      wr(`OPS_OFF_SLAVE, 32'h00000054);
      wr(`OPS_OFF_STAT, 32'h00000000);
      ti1 <= 1'b1;
      repeat (8) @(posedge pclk);
      rd("count after reset", `OPS_OFF_COUNT, 32'h6);
      apb(1'b0, `OPS_OFF_STAT, 32'h0, 4'h0);
      chk("reset flag", 32'h40, rdata & 32'h40);
      chk("reset request", 32'h1, trig_irq);
      // Gated mode: no start without run, flags on start and stop
      ti1 <= 1'b0;
      wr(`OPS_OFF_SLAVE, 32'h00000055);
      wr(`OPS_OFF_CTRL, 32'h00000080);
      wr(`OPS_OFF_COUNT, 32'h00000000);
      wr(`OPS_OFF_STAT, 32'h00000000);
      ti1 <= 1'b1;
      repeat (6) @(posedge pclk);
      rd("gated idle count", `OPS_OFF_COUNT, 32'h0);
      ti1 <= 1'b0;
      wr(`OPS_OFF_CTRL, 32'h00000081);
      wr(`OPS_OFF_STAT, 32'h00000000);
      ti1 <= 1'b1;
      repeat (6) @(posedge pclk);
      rd("gated start flag", `OPS_OFF_STAT, 32'h40);
      wr(`OPS_OFF_STAT, 32'h00000000);
      ti1 <= 1'b0;
      repeat (4) @(posedge pclk);
      apb(1'b0, `OPS_OFF_COUNT, 32'h0, 4'h0);
      c0 = rdata;
      chk("gated counted", 32'h1, (c0 !== 32'h0));
      rd("gated held", `OPS_OFF_COUNT, c0);
      rd("gated stop flag", `OPS_OFF_STAT, 32'h40);
      // Clock enable drives ready
      ce <= 1'b0;
      @(posedge pclk);
      #1;
      chk("ready low", 32'h0, pready);
      ce <= 1'b1;
      stop_test;
   end
endmodule // tb_top
